// ===== design/mac_pkg.sv
package mac_pkg;
    localparam int OPW_NATIVE_0 = 9;
    localparam int OPW_NATIVE_1 = 18;
    localparam int OPW_NATIVE_2 = 36;
    localparam int OPW_DEFAULT  = 18;
    localparam int ACW_DEFAULT  = 52;
    localparam int SEL_W        = 2;
    localparam int SRC_N        = 4;
    // Stage numbering used for the per-stage selector buses.
    localparam int STG_IN       = 0;
    localparam int STG_PIPE     = 1;
    localparam int STG_OUT      = 2;
    localparam int STG_N        = 3;
endpackage : mac_pkg

// ===== design/mac_stage_if.sv
`timescale 1ns/1ps
interface mac_stage_if;
    logic [mac_pkg::SRC_N-1:0] ce_src;
    logic [mac_pkg::SRC_N-1:0] clr_src;
    logic [mac_pkg::SEL_W-1:0] ce_sel;
    logic [mac_pkg::SEL_W-1:0] clr_sel;
    logic                      ce;
    logic                      clr;
    modport ctl (input ce_src, input clr_src, input ce_sel, input clr_sel, output ce, output clr);
    modport use_side (input ce, input clr);
endinterface : mac_stage_if

// ===== design/mac_stage_ctl.sv
`timescale 1ns/1ps
// Picks one enable and one clear out of the four shared candidates.
module mac_stage_ctl (
    mac_stage_if.ctl s      // Selector bundle for one stage
);
    always_comb begin
        s.ce  = s.ce_src[s.ce_sel];
        s.clr = s.clr_src[s.clr_sel];
    end
endmodule // mac_stage_ctl

// ===== design/mac_accumulator.sv
`timescale 1ns/1ps
module mac_accumulator #(
    parameter int OPW = mac_pkg::OPW_DEFAULT,
    parameter int ACW = mac_pkg::ACW_DEFAULT
) (
    input  wire logic                                  i_sys_clk,     // System clock, 125 MHz
    input  wire logic                                  i_sys_rst,     // Synchronous reset, active high
    input  wire logic                                  i_clk_en,      // Global clock enable
    input  wire logic [OPW-1:0]                        i_op_a,        // Multiplicand, pre-widened
    input  wire logic [OPW-1:0]                        i_op_b,        // Multiplier, pre-widened
    input  wire logic                                  i_signed,      // High for two's complement operands
    input  wire logic                                  i_load,        // High to load product instead of adding
    input  wire logic                                  i_stage_enable_src_a, // Enable candidate a
    input  wire logic                                  i_stage_enable_src_b, // Enable candidate b
    input  wire logic                                  i_stage_enable_src_c, // Enable candidate c
    input  wire logic                                  i_stage_enable_src_d, // Enable candidate d
    input  wire logic                                  i_stage_clear_src_a,  // Clear candidate a
    input  wire logic                                  i_stage_clear_src_b,  // Clear candidate b
    input  wire logic                                  i_stage_clear_src_c,  // Clear candidate c
    input  wire logic                                  i_stage_clear_src_d,  // Clear candidate d
    input  wire logic [mac_pkg::STG_N*mac_pkg::SEL_W-1:0] i_ce_sel,   // Enable choice per stage
    input  wire logic [mac_pkg::STG_N*mac_pkg::SEL_W-1:0] i_clr_sel,  // Clear choice per stage
    output logic      [ACW-1:0]                        o_acc,         // Accumulator value
    output logic                                       o_overflow     // One-cycle overflow pulse
);
    // Refuse parameter values that the datapath cannot serve.
    // Narrower operands are widened by the fabric before they arrive here.
    generate
        if (OPW != mac_pkg::OPW_NATIVE_0 && OPW != mac_pkg::OPW_NATIVE_1 &&
            OPW != mac_pkg::OPW_NATIVE_2) begin : g_bad_opw
            $error("OPW must be a native operand width");
        end
        if (ACW < 2 * OPW) begin : g_bad_acw
            $error("ACW must hold a full product");
        end
    endgenerate

    localparam int PW = 2 * OPW;

    logic [mac_pkg::STG_N-1:0] stg_ce;
    logic [mac_pkg::STG_N-1:0] stg_clr;

    // Every stage owns a selector pair; the four enable and four clear
    // candidates are shared, so two stages may well pick the same source.
    // Stage numbering follows the selector bus layout of the package.
    genvar g;
    generate
        for (g = 0; g < mac_pkg::STG_N; g++) begin : g_stage
            mac_stage_if sif ();
            assign sif.ce_src  = {i_stage_enable_src_d, i_stage_enable_src_c,
                                  i_stage_enable_src_b, i_stage_enable_src_a};
            assign sif.clr_src = {i_stage_clear_src_d, i_stage_clear_src_c,
                                  i_stage_clear_src_b, i_stage_clear_src_a};
            assign sif.ce_sel  = i_ce_sel[g*mac_pkg::SEL_W +: mac_pkg::SEL_W];
            assign sif.clr_sel = i_clr_sel[g*mac_pkg::SEL_W +: mac_pkg::SEL_W];
            mac_stage_ctl u_ctl (
                .s (sif)
            );
            assign stg_ce[g]  = sif.ce;
            assign stg_clr[g] = sif.clr;
        end
    endgenerate

    // Input stage.
    // Operands arrive already widened to OPW by the feeding logic.
    // The mode and load bits travel with the operands so that a change of
    // mode in mid-stream applies exactly to the pair it came with.
    logic [OPW-1:0] in_a;
    logic [OPW-1:0] in_b;
    logic           in_sgn;
    logic           in_load;
    logic [OPW-1:0] next_in_a;
    logic [OPW-1:0] next_in_b;
    logic           next_in_sgn;
    logic           next_in_load;

    always_comb begin
        next_in_a    = in_a;
        next_in_b    = in_b;
        next_in_sgn  = in_sgn;
        next_in_load = in_load;
        if (i_sys_rst || stg_clr[mac_pkg::STG_IN]) begin
            next_in_a    = '0;
            next_in_b    = '0;
            next_in_sgn  = 1'b0;
            next_in_load = 1'b0;
        end else if (stg_ce[mac_pkg::STG_IN]) begin
            next_in_a    = i_op_a;
            next_in_b    = i_op_b;
            next_in_sgn  = i_signed;
            next_in_load = i_load;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            in_a    <= next_in_a;
            in_b    <= next_in_b;
            in_sgn  <= next_in_sgn;
            in_load <= next_in_load;
        end
    end

    // Pipeline stage: product widened to accumulator width.
    logic [ACW-1:0] prod;
    logic           pp_sgn;
    logic           pp_load;
    logic [ACW-1:0] next_prod;
    logic           next_pp_sgn;
    logic           next_pp_load;
    logic [PW-1:0]  mult;
    logic [PW-1:0]  mult_s;
    logic [PW-1:0]  mult_u;

    // Both products are formed side by side; the mode bit only picks one.
    // The signed one treats the operand tops as signs, the other as data.
    assign mult_s = PW'($signed(in_a) * $signed(in_b));
    assign mult_u = PW'(in_a * in_b);

    always_comb begin
        mult         = in_sgn ? mult_s : mult_u;
        next_prod    = prod;
        next_pp_sgn  = pp_sgn;
        next_pp_load = pp_load;
        if (i_sys_rst || stg_clr[mac_pkg::STG_PIPE]) begin
            next_prod    = '0;
            next_pp_sgn  = 1'b0;
            next_pp_load = 1'b0;
        end else if (stg_ce[mac_pkg::STG_PIPE]) begin
            next_prod    = in_sgn ? ACW'($signed(mult)) : ACW'(mult);
            next_pp_sgn  = in_sgn;
            next_pp_load = in_load;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            prod    <= next_prod;
            pp_sgn  <= next_pp_sgn;
            pp_load <= next_pp_load;
        end
    end

    // Output stage: accumulator with wrap and overflow pulse.
    // The sum wraps modulo the accumulator width and never saturates, so
    // fabric logic can count the pulses to build a wider accumulator.
    logic [ACW-1:0] next_acc;
    logic           next_overflow;
    logic [ACW-1:0] sum;
    logic           ovf_u;
    logic           ovf_s;
    logic           acc_neg;
    logic           prod_neg;
    logic           sum_neg;
    logic           ovf_pos;
    logic           ovf_neg;

    always_comb begin
        sum      = o_acc + prod;
        // An unsigned carry out shows up as a sum below the old value.
        ovf_u    = (sum < o_acc);
        // Mixed signs can never overflow, so only like signs are tested.
        acc_neg  = o_acc[ACW-1];
        prod_neg = prod[ACW-1];
        sum_neg  = sum[ACW-1];
        ovf_pos  = !acc_neg && !prod_neg && sum_neg;
        ovf_neg  = acc_neg && prod_neg && !sum_neg;
        ovf_s    = ovf_pos || ovf_neg;
        next_acc      = o_acc;
        next_overflow = 1'b0;
        if (i_sys_rst || stg_clr[mac_pkg::STG_OUT]) begin
            next_acc = '0;
        end else if (stg_ce[mac_pkg::STG_OUT]) begin
            // A load starts a fresh sum and can therefore never wrap.
            if (pp_load) begin
                next_acc = prod;
            end else begin
                next_acc      = sum;
                next_overflow = pp_sgn ? ovf_s : ovf_u;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_acc      <= '0;
            o_overflow <= 1'b0;
        end else if (i_clk_en) begin
            o_acc      <= next_acc;
            o_overflow <= next_overflow;
        end else begin
            // The pulse is an event, not state: freezing must not stretch it,
            // or the fabric counter would see one wrap several times.
            o_overflow <= 1'b0;
        end
    end
endmodule // mac_accumulator

// ===== verif/mac_accumulator_monitor.sv
`timescale 1ns/1ps
module mac_accumulator_monitor #(
    parameter int ACW = 52
) (
    input wire logic           i_sys_clk,  // Clock
    input wire logic           i_sys_rst,  // Reset
    input wire logic           i_clk_en,   // Global enable
    input wire logic           i_signed,   // Signed mode
    input wire logic           i_stage_enable_src_a, i_stage_enable_src_b, i_stage_enable_src_c, i_stage_enable_src_d,
    input wire logic           i_stage_clear_src_a, i_stage_clear_src_b, i_stage_clear_src_c, i_stage_clear_src_d,
    input wire logic [5:0]     i_ce_sel,   // Enable choices
    input wire logic [5:0]     i_clr_sel,  // Clear choices
    input wire logic [ACW-1:0] o_acc,      // Accumulator
    input wire logic           o_overflow  // Wrap pulse
);
    wire logic [3:0] ens  = {i_stage_enable_src_d, i_stage_enable_src_c, i_stage_enable_src_b, i_stage_enable_src_a};
    wire logic [3:0] clrs = {i_stage_clear_src_d, i_stage_clear_src_c, i_stage_clear_src_b, i_stage_clear_src_a};
    wire logic       out_ce  = ens[i_ce_sel[5:4]];
    wire logic       out_clr = clrs[i_clr_sel[5:4]];
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_reset_zeroes: assert property (disable iff (1'b0) i_sys_rst |=> o_acc == '0 && !o_overflow)
        else $error("accumulator not cleared by reset");
    a_freeze_holds: assert property (!i_clk_en |=> $stable(o_acc) && !o_overflow)
        else $error("accumulator moved while frozen");
    a_out_hold: assert property (i_clk_en && !out_ce && !out_clr |=> $stable(o_acc) && !o_overflow)
        else $error("output stage ignored its enable choice");
    a_out_clear: assert property (i_clk_en && out_clr |=> o_acc == '0 && !o_overflow)
        else $error("output stage ignored its clear choice");
    a_uns_wrap: assert property (o_overflow && !i_signed |-> o_acc < $past(o_acc))
        else $error("unsigned wrap flag without smaller sum");
    a_sgn_wrap: assert property (o_overflow && i_signed |-> o_acc[ACW-1] != $past(o_acc[ACW-1]))
        else $error("signed wrap flag without sign flip");
    a_pulse_event: assert property (o_overflow |-> $past(i_clk_en) && o_acc != $past(o_acc))
        else $error("wrap pulse without an accumulate");
endmodule // mac_accumulator_monitor
bind mac_accumulator mac_accumulator_monitor #(.ACW(ACW)) u_monitor (.*);

// ===== verif/mac_fabric_model.sv
`timescale 1ns/1ps
module mac_fabric_model #(
    parameter int OPW = 9
) (
    input  wire logic           i_sys_clk,  // Clock
    input  wire logic           i_sys_rst,  // Clears count
    input  wire logic           i_signed,   // Two's complement
    input  wire logic [7:0]     i_a_narrow, // Narrow operand a
    input  wire logic [7:0]     i_b_narrow, // Narrow operand b
    input  wire logic           i_overflow, // Wrap pulse
    output logic      [OPW-1:0] o_op_a,     // Widened a
    output logic      [OPW-1:0] o_op_b,     // Widened b
    output logic      [15:0]    o_wraps     // Upper-order count
);
    logic [15:0] next_wraps;
    assign o_op_a = {{(OPW-8){i_signed & i_a_narrow[7]}}, i_a_narrow};
    assign o_op_b = {{(OPW-8){i_signed & i_b_narrow[7]}}, i_b_narrow};
    always_comb next_wraps = i_overflow ? o_wraps + 16'h1 : o_wraps;
    always_ff @(posedge i_sys_clk) o_wraps <= i_sys_rst ? 16'h0 : next_wraps;
endmodule // mac_fabric_model

// ===== verif/tb_mac_accumulator.sv
`timescale 1ns/1ps
module tb_mac_accumulator;
    localparam int ACW = 20;
    logic           i_sys_clk = 1'b0;
    logic           i_sys_rst = 1'b1;
    logic           clk_en = 1'b1, sgn = 1'b0, load = 1'b0;
    logic [3:0]     ens = 4'h1, clrs = 4'h0;
    logic [5:0]     ce_sel = 6'h00, clr_sel = 6'h00;
    logic [7:0]     na = 8'h00, nb = 8'h00;
    logic [8:0]     op_a, op_b;
    logic [ACW-1:0] acc;
    logic           ovf;
    logic [15:0]    wraps;
    int             num_errors = 0, checks = 0, cyc = 0;
    initial forever #4 i_sys_clk = ~i_sys_clk;
    mac_fabric_model #(.OPW(9)) u_fab (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_signed(sgn),
        .i_a_narrow(na), .i_b_narrow(nb), .i_overflow(ovf), .o_op_a(op_a), .o_op_b(op_b), .o_wraps(wraps));
    mac_accumulator #(.OPW(9), .ACW(ACW)) DUT (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
        .i_op_a(op_a), .i_op_b(op_b), .i_signed(sgn), .i_load(load), .i_stage_enable_src_a(ens[0]),
        .i_stage_enable_src_b(ens[1]), .i_stage_enable_src_c(ens[2]), .i_stage_enable_src_d(ens[3]),
        .i_stage_clear_src_a(clrs[0]), .i_stage_clear_src_b(clrs[1]), .i_stage_clear_src_c(clrs[2]),
        .i_stage_clear_src_d(clrs[3]), .i_ce_sel(ce_sel), .i_clr_sel(clr_sel), .o_acc(acc), .o_overflow(ovf));
    task automatic check(input string what, input logic [ACW-1:0] seen, input logic [ACW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Loads the first product, adds the rest back to back, then flushes zeros through the pipe.
    task automatic run_sum(input logic s, input logic [7:0] a, input logic [7:0] b, input int n,
                           input logic [ACW-1:0] exp, input logic [15:0] exp_w);
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        sgn <= s;
        for (int k = 0; k < n; k++) begin
            na <= a;
            nb <= b;
            load <= (k == 0);
            @(posedge i_sys_clk);
        end
        na <= 8'h00;
        nb <= 8'h00;
        load <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        check("acc", acc, exp);
        check("wraps", ACW'(wraps), ACW'(exp_w));
        @(posedge i_sys_clk);
    endtask
    task automatic hold_clear();
        run_sum(1'b0, 8'h03, 8'h04, 1, 20'h0000c, 16'h0000);
        ce_sel <= 6'h10;
        na <= 8'h02;
        nb <= 8'h02;
        repeat (2) @(posedge i_sys_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check("held acc", acc, 20'h0000c);
        @(posedge i_sys_clk);
        clk_en <= 1'b1;
        clrs <= 4'h4;
        clr_sel <= 6'h20;
        repeat (2) @(posedge i_sys_clk);
        #1;
        check("cleared acc", acc, 20'h00000);
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        run_sum(1'b0, 8'h03, 8'h04, 1, 20'h0000c, 16'h0000);
        run_sum(1'b1, 8'hfa, 8'h05, 2, 20'hfffc4, 16'h0000);
        run_sum(1'b0, 8'hff, 8'hff, 20, 20'h3d814, 16'h0001);
        run_sum(1'b1, 8'h80, 8'h7f, 40, 20'h61400, 16'h0001);
        hold_clear();
        tally_and_finish();
    end
endmodule // tb_mac_accumulator
